/* rtl/vds_params.svh */
`ifndef VDS_PARAMS_SVH
`define VDS_PARAMS_SVH
// register indices, byte address is four times the index
`define VDS_IDX_HRATIO_HI 8'h08
`define VDS_IDX_HRATIO_LO 8'h09
`define VDS_IDX_VRATIO_HI 8'h13
`define VDS_IDX_VRATIO_LO 8'h14
`define VDS_IDX_VTAP 8'h20
`define VDS_IDX_LOOP 8'h21
`define VDS_IDX_STATUS 8'h22
// reset values
`define VDS_RST_BYTE 8'h00
`define VDS_RST_VTAP 2'h0
`define VDS_RST_LOOP 3'h0
// field positions
`define VDS_INT_BIT 5
`define VDS_PEAK_BIT 2
// horizontal step in 1/4096 sample
`define VDS_HUNIT 18'h01000
`define VDS_HMAX 18'h10000
// vertical step in 1/512 line
`define VDS_VUNIT 15'h0200
`define VDS_VMAX_FRAME 15'h2000
`define VDS_VMAX_FIELD 15'h1000
`define VDS_VWRAP 14'h2000
// unscaled ntsc samples per line
`define VDS_NTSC_LINE 11'h38e
`endif

/* rtl/vds_pkg.sv */
package vds_pkg;
  // one sample of the luma and chroma streams
  typedef struct packed {
    logic [7:0] luma;
    logic [7:0] chroma;
  } vds_pixel_t;
  // status word as read by software
  typedef struct packed {
    logic [4:0] pad_hi;
    logic [10:0] lines;
    logic [4:0] pad_lo;
    logic [10:0] pixels;
  } vds_status_t;
endpackage

/* rtl/vds_scaler.sv */
// Decided for this implementation: the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none
`include "vds_params.svh"

// Behaviour
// - scaling settings live in own registers, independent of cropping and decimation
// - horizontal and vertical ratios are arbitrary and independent, clamped at 16:1
// - in single-field mode the vertical step is clamped at 8:1
// - optional luma low-pass pre-filter before interpolation, chosen by software
// - horizontal luma interpolation resolves output position to 32 phases
// - four stored lines feed the vertical luma low-pass filter
// - vertical tap count field selects 2, 3, 4 or 5 taps
// - vertical interpolation positions lines for non-integer ratios
// - peaking enable with prefilter select bits gives four peaking levels
// - chroma uses 2-tap, 32-phase interpolation with the luma ratio
// - chroma is combed over the line store then lines are dropped
// - with zero horizontal ratio every input sample is passed, 910 per ntsc line
// - horizontal ratio is high byte and low byte joined into 16 bits
// - horizontal ratio encodes (nominal/desired - 1) times 4096
// - vertical ratio is 13-bit negative: 0x10000 - (ratio-1)*512, masked
// - vertical ratio uses 13 bits; top three high-byte bits are other controls
module vds_scaler
  import vds_pkg::*;
#(
  parameter int MAX_LINE = 1024,
  parameter bit PEAKING = 1'b1
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic in_valid,
  input wire logic in_line_start,
  input wire logic in_field_start,
  input wire vds_pixel_t in_pix,
  output logic out_valid,
  output logic out_line_start,
  output logic out_field_start,
  output vds_pixel_t out_pix
);

  localparam int XW = $clog2(MAX_LINE);

  // ****************************************************************
  // register bus
  // ****************************************************************

  logic dp_valid;
  logic dp_write;
  logic [7:0] dp_idx;
  logic [7:0] hr_hi, hr_lo, vr_hi, vr_lo;
  logic [1:0] vtap;
  logic [2:0] loopc;
  logic [7:0] next_hr_hi, next_hr_lo, next_vr_hi, next_vr_lo;
  logic [1:0] next_vtap;
  logic [2:0] next_loopc;
  vds_status_t status;
  logic [31:0] rd_word;
  wire take = hsel & hready & htrans[1];
  wire [7:0] a_idx = haddr[9:2];
  wire wr_en = dp_valid & dp_write & hready;

  // zero wait states; no access can fail
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // address phase captured for the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_idx <= 8'h00;
    end else if (hready) begin
      dp_valid <= take;
      dp_write <= hwrite;
      dp_idx <= a_idx;
    end
  end

  // write data merged into next values; reads see them, so a read right after
  // a write to the same word returns the new value
  always_comb begin
    next_hr_hi = hr_hi;
    next_hr_lo = hr_lo;
    next_vr_hi = vr_hi;
    next_vr_lo = vr_lo;
    next_vtap = vtap;
    next_loopc = loopc;
    if (wr_en) begin
      case (dp_idx)
        `VDS_IDX_HRATIO_HI: next_hr_hi = hwdata[7:0];
        `VDS_IDX_HRATIO_LO: next_hr_lo = hwdata[7:0];
        `VDS_IDX_VRATIO_HI: next_vr_hi = hwdata[7:0];
        `VDS_IDX_VRATIO_LO: next_vr_lo = hwdata[7:0];
        `VDS_IDX_VTAP: next_vtap = hwdata[1:0];
        `VDS_IDX_LOOP: next_loopc = hwdata[2:0];
        default: ;
      endcase
    end
  end

  // scaling controls only; no other data-reduction stage reads them
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hr_hi <= `VDS_RST_BYTE;
      hr_lo <= `VDS_RST_BYTE;
      vr_hi <= `VDS_RST_BYTE;
      vr_lo <= `VDS_RST_BYTE;
      vtap <= `VDS_RST_VTAP;
      loopc <= `VDS_RST_LOOP;
    end else begin
      hr_hi <= next_hr_hi;
      hr_lo <= next_hr_lo;
      vr_hi <= next_vr_hi;
      vr_lo <= next_vr_lo;
      vtap <= next_vtap;
      loopc <= next_loopc;
    end
  end

  // read mux; unmapped words read as zero
  always_comb begin
    case (a_idx)
      `VDS_IDX_HRATIO_HI: rd_word = {24'h000000, next_hr_hi};
      `VDS_IDX_HRATIO_LO: rd_word = {24'h000000, next_hr_lo};
      `VDS_IDX_VRATIO_HI: rd_word = {24'h000000, next_vr_hi};
      `VDS_IDX_VRATIO_LO: rd_word = {24'h000000, next_vr_lo};
      `VDS_IDX_VTAP: rd_word = {30'h00000000, next_vtap};
      `VDS_IDX_LOOP: rd_word = {29'h00000000, next_loopc};
      `VDS_IDX_STATUS: rd_word = status;
      default: rd_word = 32'h00000000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (hready) begin
      hrdata <= (take & ~hwrite) ? rd_word : 32'h00000000;
    end
  end

  // ****************************************************************
  // horizontal scaling
  // ****************************************************************

  function automatic logic [7:0] blend(input logic [7:0] a, input logic [7:0] b,
                                       input logic [4:0] p);
    logic [12:0] s;
    s = 13'(a) * (13'h0020 - 13'(p)) + 13'(b) * 13'(p);
    return s[12:5];
  endfunction

  logic [7:0] y1, y2, c1, py, pc, cur_y;
  logic [17:0] hacc;
  logic [XW-1:0] hx_cnt, hx;
  logic hv;
  vds_pixel_t hpix;
  wire [17:0] hsum = `VDS_HUNIT + {2'b00, hr_hi, hr_lo};
  wire [17:0] hstep = (hsum > `VDS_HMAX) ? `VDS_HMAX : hsum;
  wire hemit = hacc < `VDS_HUNIT;
  wire [4:0] hph = hacc[11:7];
  wire [9:0] lp_sum = 10'(in_pix.luma) + 10'({y1, 1'b0}) + 10'(y2);
  wire signed [11:0] hp = $signed({3'b000, y1, 1'b0}) - $signed({4'h0, in_pix.luma})
                          - $signed({4'h0, y2});
  wire [2:0] pk_sh = 3'h4 - {1'b0, loopc[1:0]};
  wire signed [11:0] pk = $signed({4'h0, y1}) + (hp >>> pk_sh);

  // luma shaping: peaking wins over the pre-filter when both are asked for
  always_comb begin
    if (PEAKING && loopc[`VDS_PEAK_BIT]) begin
      if (pk < 0) begin
        cur_y = 8'h00;
      end else if (pk > 12'sh0ff) begin
        cur_y = 8'hff;
      end else begin
        cur_y = pk[7:0];
      end
    end else if (loopc[1:0] != 2'h0) begin
      cur_y = lp_sum[9:2];
    end else begin
      cur_y = y1;
    end
  end

  // sample history for the filters and the interpolator
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      y1 <= 8'h00;
      y2 <= 8'h00;
      c1 <= 8'h00;
      py <= 8'h00;
      pc <= 8'h00;
    end else if (in_valid) begin
      y1 <= in_pix.luma;
      y2 <= y1;
      c1 <= in_pix.chroma;
      py <= cur_y;
      pc <= c1;
    end
  end

  // phase accumulator: at most one output per input since ratios only shrink
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hacc <= 18'h00000;
    end else if (in_line_start) begin
      hacc <= 18'h00000;
    end else if (in_valid) begin
      hacc <= hemit ? hacc + hstep - `VDS_HUNIT : hacc - `VDS_HUNIT;
    end
  end

  // interpolated pixel and its column within the line
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hv <= 1'b0;
      hpix <= '0;
      hx <= '0;
      hx_cnt <= '0;
    end else begin
      hv <= in_valid & hemit & ~in_line_start;
      if (in_line_start) begin
        hx_cnt <= '0;
      end else if (in_valid & hemit) begin
        hpix.luma <= blend(py, cur_y, hph);
        hpix.chroma <= blend(pc, c1, hph);
        hx <= hx_cnt;
        // columns past the store saturate rather than wrap
        if (hx_cnt != XW'(MAX_LINE - 1)) begin
          hx_cnt <= hx_cnt + 1'b1;
        end
      end
    end
  end

  // ****************************************************************
  // vertical scaling
  // ****************************************************************

  vds_pixel_t tap [5];
  assign tap[0] = hpix;

  // four line stores shift one line down per output column
  genvar k;
  generate
    for (k = 0; k < 4; k++) begin : g_line
      vds_pixel_t mem [MAX_LINE];
      assign tap[k+1] = mem[hx];
      always_ff @(posedge hclk) begin
        if (hv) begin
          mem[hx] <= tap[k];
        end
      end
    end
  endgenerate

  function automatic logic [7:0] vertical_tap_count(input logic [1:0] n, input logic [7:0] l0,
                                       input logic [7:0] l1, input logic [7:0] l2,
                                       input logic [7:0] l3, input logic [7:0] l4);
    logic [11:0] s;
    s = 12'h000;
    case (n)
      2'h0: s = 12'(l0) + 12'(l1);
      2'h1: s = 12'(l0) + 12'({l1, 1'b0}) + 12'(l2);
      2'h2: s = 12'(l0) + 12'(l1) * 12'h003 + 12'(l2) * 12'h003 + 12'(l3);
      default: s = 12'(l0) + 12'({l1, 2'b00}) + 12'(l2) * 12'h006
                   + 12'({l3, 2'b00}) + 12'(l4);
    endcase
    case (n)
      2'h0: return s[8:1];
      2'h1: return s[9:2];
      2'h2: return s[10:3];
      default: return s[11:4];
    endcase
  endfunction

  logic [14:0] vacc;
  logic [4:0] vph;
  logic keep;
  wire [12:0] vratio = {vr_hi[4:0], vr_lo};
  wire [12:0] vdiff = 13'(`VDS_VWRAP - {1'b0, vratio});
  wire [14:0] vsum = `VDS_VUNIT + {2'b00, vdiff};
  // single-field mode halves the reachable reduction
  wire [14:0] vmax = vr_hi[`VDS_INT_BIT] ? `VDS_VMAX_FRAME : `VDS_VMAX_FIELD;
  wire [14:0] vstep = (vsum > vmax) ? vmax : vsum;
  wire next_keep = vacc < `VDS_VUNIT;
  wire [7:0] vf = vertical_tap_count(vtap, tap[0].luma, tap[1].luma, tap[2].luma,
                        tap[3].luma, tap[4].luma);
  wire [8:0] comb_c = 9'(tap[0].chroma) + 9'(tap[1].chroma);

  // per-line decision: keep or drop, and the line phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vacc <= 15'h0000;
      vph <= 5'h00;
      keep <= 1'b0;
    end else if (in_field_start) begin
      vacc <= 15'h0000;
    end else if (in_line_start) begin
      keep <= next_keep;
      vph <= vacc[8:4];
      vacc <= next_keep ? vacc + vstep - `VDS_VUNIT : vacc - `VDS_VUNIT;
    end
  end

  // output stage; the interpolation pulls toward the line above
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_valid <= 1'b0;
      out_line_start <= 1'b0;
      out_field_start <= 1'b0;
      out_pix <= '0;
    end else begin
      out_valid <= hv & keep;
      out_line_start <= in_line_start & ~in_field_start & next_keep;
      out_field_start <= in_field_start;
      if (hv & keep) begin
        out_pix.luma <= blend(vf, tap[1].luma, vph);
        out_pix.chroma <= comb_c[8:1];
      end
    end
  end

  // ****************************************************************
  // status counters
  // ****************************************************************

  logic [10:0] pix_cnt, line_cnt;

  // last line's pixel count and last field's line count
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pix_cnt <= 11'h000;
      line_cnt <= 11'h000;
      status <= '0;
    end else begin
      if (in_line_start) begin
        status.pixels <= pix_cnt;
        pix_cnt <= 11'h000;
      end else if (hv & keep) begin
        pix_cnt <= pix_cnt + 11'h001;
      end
      if (in_field_start) begin
        status.lines <= line_cnt;
        line_cnt <= 11'h000;
      end else if (in_line_start & next_keep) begin
        line_cnt <= line_cnt + 11'h001;
      end
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_hstep_cap: assert property (hstep <= `VDS_HMAX && hstep >= `VDS_HUNIT)
    else $error("horizontal step outside 1:1..16:1");
  a_vfield_cap: assert property (!vr_hi[`VDS_INT_BIT] |-> vstep <= `VDS_VMAX_FIELD)
    else $error("field mode step above 8:1");
  a_unity_pass: assert property ((hstep == `VDS_HUNIT && hacc == 18'h0 && in_valid
    && !in_line_start) |=> hv ##1 out_valid == keep)
    else $error("unscaled sample not passed");
  a_valid_cause: assert property (out_valid |-> $past(hv) && $past(keep))
    else $error("output valid without a kept pixel");
  a_drop_line: assert property ((in_line_start && !in_field_start && !next_keep)
    |=> !keep && !out_valid)
    else $error("dropped line not dropped");
  a_hratio_wr: assert property ((wr_en && dp_idx == `VDS_IDX_HRATIO_LO)
    |=> hsum[7:0] == $past(hwdata[7:0]))
    else $error("low ratio byte not applied");
  a_vratio_math: assert property ((wr_en && dp_idx == `VDS_IDX_VRATIO_LO
    && hwdata[7:0] == 8'h00 && vr_hi[4:0] == 5'h1a) |=> vdiff == 13'h0600)
    else $error("vertical ratio decode wrong");
  a_top_bits: assert property ((wr_en && dp_idx == `VDS_IDX_VRATIO_LO)
    |=> $stable(vr_hi[7:5]))
    else $error("control bits disturbed");
  a_peak_sel: assert property ((PEAKING && loopc[`VDS_PEAK_BIT] && hp == 12'sh0)
    |-> cur_y == y1)
    else $error("peaking alters flat luma");
  a_read_back: assert property ((take && !hwrite && a_idx == `VDS_IDX_VTAP)
    |=> hrdata == {30'h0, vtap})
    else $error("tap field read wrong");

  c_ntsc_line: cover property (in_line_start && status.pixels == `VDS_NTSC_LINE);
  c_five_taps: cover property (out_valid && vtap == 2'h3);
  c_peaking: cover property (hv && loopc[`VDS_PEAK_BIT] && loopc[1:0] == 2'h3);
  c_line_drop: cover property (in_line_start && !next_keep);

endmodule
`default_nettype wire

/* test/vds_video_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// decoder front end and pixel sink model
// ****************************************
module vds_video_model
  import vds_pkg::*;
(
  input wire logic hclk,
  input wire logic out_valid,
  input wire logic out_line_start,
  output logic in_valid,
  output logic in_line_start,
  output logic in_field_start,
  output vds_pixel_t in_pix,
  output int n_pix,
  output int n_lines
);
  // idle front end at time zero
  initial begin
    in_valid = 1'b0;
    in_line_start = 1'b0;
    in_field_start = 1'b0;
    in_pix = 16'h0000;
    n_pix = 0;
    n_lines = 0;
  end

  // sink never pushes back, it only counts pixels and kept lines
  always @(posedge hclk) begin
    if (out_valid === 1'b1)
      n_pix <= n_pix + 1;
    if (out_line_start === 1'b1)
      n_lines <= n_lines + 1;
  end

  // field pulse, then a quiet cycle; with the line task's own first edge, two quiet cycles before the first line pulse
  task automatic field();
    @(posedge hclk);
    in_field_start <= 1'b1;
    @(posedge hclk);
    in_field_start <= 1'b0;
    @(posedge hclk);
  endtask

  // line pulse, one gap cycle, back-to-back samples, then drain time;
  // released data shows the inverse so a stale sample never looks fresh
  task automatic line(input int n, input vds_pixel_t p);
    @(posedge hclk);
    in_line_start <= 1'b1;
    @(posedge hclk);
    in_line_start <= 1'b0;
    @(posedge hclk);
    repeat (n) begin
      in_valid <= 1'b1;
      in_pix <= p;
      @(posedge hclk);
    end
    in_valid <= 1'b0;
    in_pix <= ~p;
    repeat (4) @(posedge hclk);
  endtask
endmodule
`default_nettype wire

/* test/vds_scaler_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
`include "vds_params.svh"
// ****************************************
// scaler bench
// ****************************************
module vds_scaler_tb_top
  import vds_pkg::*;
;
  logic hclk;
  logic hresetn;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic in_valid, in_line_start, in_field_start;
  logic out_valid, out_line_start, out_field_start;
  vds_pixel_t in_pix, out_pix;
  int n_pix, n_lines, n_fail, n_tests;
  int n_fld = 0;

  // field pulses seen on the output side; nothing else watches that pin
  always @(posedge hclk) begin
    if (out_field_start === 1'b1) begin
      n_fld <= n_fld + 1;
    end
  end

  // single slave, so its ready is the bus ready
  vds_scaler #(.MAX_LINE(64), .PEAKING(1'b1)) vds_scaler_inst (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .in_valid(in_valid), .in_line_start(in_line_start),
    .in_field_start(in_field_start), .in_pix(in_pix), .out_valid(out_valid),
    .out_line_start(out_line_start), .out_field_start(out_field_start), .out_pix(out_pix));

  vds_video_model vds_video_model_inst (.hclk(hclk), .out_valid(out_valid),
    .out_line_start(out_line_start), .in_valid(in_valid), .in_line_start(in_line_start),
    .in_field_start(in_field_start), .in_pix(in_pix), .n_pix(n_pix), .n_lines(n_lines));

  // 100 MHz clock
  initial hclk = 1'b0;
  always #5 hclk = ~hclk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one single transfer; the wait ends only on ready, the watchdog guards it
  task automatic ahb(input logic w, input logic [7:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {22'h000000, idx, 2'b00};
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
    chk({31'h00000000, hresp}, 32'h00000000);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, idx, d, x);
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] e);
    logic [31:0] x;
    ahb(1'b0, idx, 32'h00000000, x);
    chk(x, e);
  endtask

  // reset values, field widths, read-only status and an unmapped place
  task automatic t_regs();
    logic [7:0] idx [7] = '{`VDS_IDX_HRATIO_HI, `VDS_IDX_HRATIO_LO, `VDS_IDX_VRATIO_HI,
      `VDS_IDX_VRATIO_LO, `VDS_IDX_VTAP, `VDS_IDX_LOOP, `VDS_IDX_STATUS};
    foreach (idx[i]) rd_chk(idx[i], 32'h00000000);
    for (int k = 0; k < 4; k++) begin
      wr(`VDS_IDX_VTAP, k);
      rd_chk(`VDS_IDX_VTAP, k);
    end
    wr(`VDS_IDX_LOOP, 32'hffffffff);
    rd_chk(`VDS_IDX_LOOP, 32'h00000007);
    wr(`VDS_IDX_VRATIO_HI, 32'hffffffff);
    rd_chk(`VDS_IDX_VRATIO_HI, 32'h000000ff);
    wr(`VDS_IDX_STATUS, 32'hffffffff);
    rd_chk(`VDS_IDX_STATUS, 32'h00000000);
    wr(8'h30, 32'hffffffff);
    rd_chk(8'h30, 32'h00000000);
    wr(`VDS_IDX_LOOP, 32'h00000000);
    wr(`VDS_IDX_VRATIO_HI, 32'h00000000);
  endtask

  // pixels kept from a 32-sample line, including a fractional and an over-range ratio
  task automatic t_horizontal_ratio();
    logic [15:0] hr [6] = '{16'h0000, 16'h1000, 16'h0800, 16'h3000, 16'hf000, 16'hffff};
    int ex [6] = '{32, 16, 22, 8, 2, 2};
    logic [31:0] x;
    int c;
    foreach (hr[i]) begin
      wr(`VDS_IDX_HRATIO_HI, {24'h000000, hr[i][15:8]});
      wr(`VDS_IDX_HRATIO_LO, {24'h000000, hr[i][7:0]});
      rd_chk(`VDS_IDX_HRATIO_HI, {24'h000000, hr[i][15:8]});
      rd_chk(`VDS_IDX_HRATIO_LO, {24'h000000, hr[i][7:0]});
      vds_video_model_inst.field();
      c = n_pix;
      vds_video_model_inst.line(32, 16'h1234);
      chk(n_pix - c, ex[i]);
      // an empty line latches the pixel count of the line before into status
      vds_video_model_inst.line(0, 16'h0000);
      ahb(1'b0, `VDS_IDX_STATUS, 32'h00000000, x);
      chk({21'h000000, x[10:0]}, ex[i]);
    end
    wr(`VDS_IDX_HRATIO_HI, 32'h00000000);
    wr(`VDS_IDX_HRATIO_LO, 32'h00000000);
  endtask

  // lines kept from a 16-line field, frame and single-field modes
  task automatic t_vertical_ratio();
    logic it [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
    int r [5] = '{1, 2, 16, 16, 4};
    int ex [5] = '{16, 8, 1, 2, 4};
    logic [12:0] vr;
    logic [31:0] hi;
    int c;
    int f;
    foreach (r[i]) begin
      f = n_fld;
      wr(`VDS_IDX_VRATIO_HI, {24'h000000, 2'b10, it[i], 5'h00});
      vr = 13'((32'h00010000 - (r[i] - 1) * 512) & 32'h00001fff);
      ahb(1'b0, `VDS_IDX_VRATIO_HI, 32'h00000000, hi);
      wr(`VDS_IDX_VRATIO_HI, {24'h000000, hi[7:5], vr[12:8]});
      wr(`VDS_IDX_VRATIO_LO, {24'h000000, vr[7:0]});
      rd_chk(`VDS_IDX_VRATIO_HI, {24'h000000, 2'b10, it[i], vr[12:8]});
      vds_video_model_inst.field();
      c = n_lines;
      repeat (16) vds_video_model_inst.line(1, 16'h0f0f);
      chk(n_lines - c, ex[i]);
      chk(n_fld - f, 1);
      // the next field pulse latches the kept-line count of this field
      vds_video_model_inst.field();
      ahb(1'b0, `VDS_IDX_STATUS, 32'h00000000, hi);
      chk({21'h000000, hi[26:16]}, ex[i]);
    end
    wr(`VDS_IDX_VRATIO_HI, 32'h00000000);
    wr(`VDS_IDX_VRATIO_LO, 32'h00000000);
  endtask

  // a flat picture must come through every loop setting with five vertical taps unchanged
  task automatic t_pix();
    vds_pixel_t p = 16'h5a3c;
    wr(`VDS_IDX_VTAP, 32'h00000003);
    vds_video_model_inst.field();
    repeat (5) vds_video_model_inst.line(16, p);
    for (int k = 0; k < 8; k++) begin
      wr(`VDS_IDX_LOOP, k);
      rd_chk(`VDS_IDX_LOOP, k);
      repeat (2) vds_video_model_inst.line(16, p);
      chk({16'h0000, out_pix}, {16'h0000, p});
    end
    // a flat picture hides a dead filter, so a step between lines must average
    wr(`VDS_IDX_VTAP, 32'h00000000);
    wr(`VDS_IDX_LOOP, 32'h00000000);
    repeat (2) vds_video_model_inst.line(16, 16'h2040);
    vds_video_model_inst.line(16, 16'h6080);
    chk({16'h0000, out_pix}, 32'h00004060);
  endtask

  task automatic test_done();
    $display("checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // reset for six cycles, then the scenarios in turn
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    n_fail = 0;
    n_tests = 0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_horizontal_ratio();
    t_vertical_ratio();
    t_pix();
    test_done();
  end

  // the run needs about two thousand cycles; ten times that means a hang
  initial begin
    #200000;
    n_fail++;
    test_done();
  end
endmodule
`default_nettype wire
